// ===== common/pot_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pot_link_if;
    logic port_enable;
    logic serial_clk;
    logic host_data;
    logic host_data_oe;
    logic cascade_out;
    wire serial_data = host_data_oe ? host_data : cascade_out;
    modport device (
        input port_enable,
        input serial_clk,
        input serial_data,
        output cascade_out
    );
    modport host (
        output port_enable,
        output serial_clk,
        output host_data,
        output host_data_oe,
        input cascade_out
    );
endinterface
`default_nettype wire

// ===== common/pot_port_pkg.sv
package pot_port_pkg;
    localparam int FRAME_BITS = 17;
    localparam int CODE_BITS = 8;
    localparam int TAP_COUNT = 256;
    localparam int STACK_POS = 0;
    localparam int CODE_ONE_MSB_POS = 1;
    localparam int CODE_ZERO_MSB_POS = 9;
    localparam int REF_CLK_MHZ = 200;
    localparam int LINK_HALF_NS = 300;
    localparam int LINK_HALF_CYCLES = (LINK_HALF_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int ENABLE_SETUP_NS = 125;
    localparam int ENABLE_SETUP_CYCLES = (ENABLE_SETUP_NS * REF_CLK_MHZ + 999) / 1000;
    localparam logic [FRAME_BITS-1:0] FRAME_RESET = 17'h00000;
endpackage

// ===== rtl/pot_device_end.sv
// Overview of operation
// - Eight-bit code picks one of 256 taps.
// - Port ignores everything while enable low.
// - Data captured on rising serial clock.
// - Seventeen bits: stack, code one, code zero.
// - Frame order: stack, code one, code zero.
// - Host sends seventeen bits or multiples.
// - Host drops enable after each transaction.
// - Wipers load only on enable falling.
// - Wipers reset to zero; wipers_valid stays low until first completed transaction.
// - Stack bit zero selects wiper zero.
// - Cascade output shows bit being shifted out.
// - Idle cascade output shows stack bit.
// - Chain needs seventeen times N clocks.
// - Host floats data line during readback.
// - Enable high exposes last register bit.
// - Circular readback reloads unchanged values.
`timescale 1ns/1ps
`default_nettype none
module pot_device_end
    import pot_port_pkg::*;
#(
    parameter int BITS = FRAME_BITS,
    parameter int CODE_W = CODE_BITS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    pot_link_if.device link,
    output logic [CODE_W-1:0] wiper_zero,
    output logic [CODE_W-1:0] wiper_one,
    output logic stack_select,
    output logic wipers_valid,
    output logic [2**CODE_W-1:0] tap_zero,
    output logic [2**CODE_W-1:0] tap_one,
    output logic [CODE_W-1:0] stacked_code,
    output logic stacked_is_one
);
    logic [2:0] sync_pins;
    logic enable_s;
    logic clk_s;
    logic data_s;
    logic enable_d;
    logic clk_d;
    logic [BITS-1:0] shift;
    logic [BITS-1:0] next_shift;
    logic rise;
    logic fall_enable;
    logic [CODE_W-1:0] code_zero_w;
    logic [CODE_W-1:0] code_one_w;
    logic next_cascade;
    logic [CODE_W-1:0] next_wiper_zero;
    logic [CODE_W-1:0] next_wiper_one;
    logic next_stack_select;
    logic next_wipers_valid;
    logic [2**CODE_W-1:0] next_tap_zero;
    logic [2**CODE_W-1:0] next_tap_one;
    logic [CODE_W-1:0] next_stacked_code;

    function automatic logic [CODE_W-1:0] field_msb_first(input logic [BITS-1:0] r,
                                                          input int msb_pos);
        logic [CODE_W-1:0] v;
        v = '0;
        for (int i = 0; i < CODE_W; i++)
            v[CODE_W-1-i] = r[msb_pos+i];
        return v;
    endfunction

    function automatic logic [2**CODE_W-1:0] one_hot(input logic [CODE_W-1:0] c);
        logic [2**CODE_W-1:0] v;
        v = '0;
        v[c] = 1'b1;
        return v;
    endfunction

    pot_sync2 #(.WIDTH(3)) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in({link.port_enable, link.serial_clk, link.serial_data}),
        .sync_out(sync_pins)
    );

    assign enable_s = sync_pins[2];
    assign clk_s = sync_pins[1];
    assign data_s = sync_pins[0];
    assign rise = enable_s && enable_d && clk_s && !clk_d;
    assign fall_enable = enable_d && !enable_s;
    assign code_zero_w = field_msb_first(shift, CODE_ZERO_MSB_POS);
    assign code_one_w = field_msb_first(shift, CODE_ONE_MSB_POS);
    // hold while disabled
    // New bits move down from the top, so the first bit of a frame ends in bit 0.
    assign next_shift = rise ? {data_s, shift[BITS-1:1]} : shift;
    // bit 0 goes out
    // Bit 0 is both the next bit to leave and the stack bit, so one tap serves both states.
    assign next_cascade = next_shift[STACK_POS];
    assign next_wiper_zero = fall_enable ? code_zero_w : wiper_zero;
    assign next_wiper_one = fall_enable ? code_one_w : wiper_one;
    assign next_stack_select = fall_enable ? shift[STACK_POS] : stack_select;
    assign next_wipers_valid = fall_enable || wipers_valid;
    assign next_tap_zero = one_hot(wiper_zero);
    assign next_tap_one = one_hot(wiper_one);
    assign next_stacked_code = stack_select ? wiper_one : wiper_zero;

    // Edge history for the synchronised enable and clock pins.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            enable_d <= 1'b0;
        else
            enable_d <= enable_s;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            clk_d <= 1'b0;
        else
            clk_d <= clk_s;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            shift <= FRAME_RESET;
        else
            shift <= next_shift;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            link.cascade_out <= 1'b0;
        else
            link.cascade_out <= next_cascade;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wiper_zero <= '0;
        else
            wiper_zero <= next_wiper_zero;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wiper_one <= '0;
        else
            wiper_one <= next_wiper_one;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            stack_select <= 1'b0;
        else
            stack_select <= next_stack_select;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wipers_valid <= 1'b0;
        else
            wipers_valid <= next_wipers_valid;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            tap_zero <= '0;
        else
            tap_zero <= next_tap_zero;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            tap_one <= '0;
        else
            tap_one <= next_tap_one;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            stacked_code <= '0;
        else
            stacked_code <= next_stacked_code;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            stacked_is_one <= 1'b0;
        else
            stacked_is_one <= stack_select;
    end
endmodule
`default_nettype wire

// ===== rtl/pot_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module pot_host_end
    import pot_port_pkg::*;
#(
    parameter int BITS = FRAME_BITS,
    parameter int MAX_DEVICES = 4,
    parameter int HALF = LINK_HALF_CYCLES,
    parameter int GAP = ENABLE_SETUP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    pot_link_if.host link,
    input wire logic start,
    input wire logic readback,
    input wire logic [2:0] devices,
    input wire logic [BITS*MAX_DEVICES-1:0] tx_frame,
    output logic busy,
    output logic done,
    output logic [BITS*MAX_DEVICES-1:0] rx_frame
);
    typedef enum {IDLE, SETUP, LOW, HIGH, HOLD, GAP_WAIT} host_state_t;
    localparam int TOTAL = BITS * MAX_DEVICES;
    host_state_t state;
    logic [15:0] timer;
    logic [15:0] bit_left;
    logic [TOTAL-1:0] tx;
    logic casc_s;
    logic casc_m;
    logic timer_done;

    assign timer_done = (timer == 16'h0000);

    // Cascade output comes from another clock domain, so it is resynchronised here.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            casc_m <= 1'b0;
            casc_s <= 1'b0;
        end
        else
        begin
            casc_m <= link.cascade_out;
            casc_s <= casc_m;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= IDLE;
            timer <= 16'h0000;
            bit_left <= 16'h0000;
            tx <= '0;
            rx_frame <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            link.port_enable <= 1'b0;
            link.serial_clk <= 1'b0;
            link.host_data <= 1'b0;
            link.host_data_oe <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (!timer_done)
                timer <= timer - 16'h0001;
            case (state)
                IDLE:
                begin
                    if (start)
                    begin
                        // whole frames, one per chained device
                        bit_left <= 16'(BITS) * 16'(devices);
                        tx <= tx_frame;
                        busy <= 1'b1;
                        // raise enable to open a transaction
                        link.port_enable <= 1'b1;
                        link.host_data_oe <= !readback;
                        timer <= 16'(GAP);
                        state <= SETUP;
                    end
                end
                SETUP:
                begin
                    if (timer_done)
                    begin
                        // stack bit of the farthest device in the chain goes first
                        link.host_data <= tx[0];
                        timer <= 16'(HALF);
                        state <= LOW;
                    end
                end
                LOW:
                begin
                    if (timer_done)
                    begin
                        link.serial_clk <= 1'b1;
                        rx_frame <= {casc_s, rx_frame[TOTAL-1:1]};
                        bit_left <= bit_left - 16'h0001;
                        timer <= 16'(HALF);
                        state <= HIGH;
                    end
                end
                HIGH:
                begin
                    if (timer_done)
                    begin
                        link.serial_clk <= 1'b0;
                        tx <= {1'b0, tx[TOTAL-1:1]};
                        link.host_data <= tx[1];
                        timer <= 16'(HALF);
                        state <= (bit_left == 16'h0000) ? HOLD : LOW;
                    end
                end
                HOLD:
                begin
                    if (timer_done)
                    begin
                        link.port_enable <= 1'b0;
                        link.host_data_oe <= 1'b0;
                        timer <= 16'(GAP);
                        state <= GAP_WAIT;
                    end
                end
                GAP_WAIT:
                begin
                    if (timer_done)
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= IDLE;
                    end
                end
                default:
                    state <= IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pot_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module pot_sync2 #(
    parameter int WIDTH = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // Two flops guard against metastability on pins from the link.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage_one <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule
`default_nettype wire

// ===== tb/dual_pot_serial_shift_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_pot_serial_shift_port_tb
    import pot_port_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic readback = 1'b0;
    logic [2:0] devices = 3'h1;
    logic [67:0] tx_frame = 68'h0;
    logic [67:0] rx_frame;
    logic busy, done, stack_select, wipers_valid, stacked_is_one;
    logic [7:0] wiper_zero, wiper_one, stacked_code;
    logic [255:0] tap_zero, tap_one;
    logic [16:0] reg_now = 17'h0;
    logic loaded = 1'b0;
    int n_errors = 0;
    int n_checks = 0;
    int seed = 32'h450b;
    pot_link_if link_bus();
    always #2.5 ref_clk = ~ref_clk;
    pot_device_end pot_device_end_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .link(link_bus.device), .wiper_zero(wiper_zero), .wiper_one(wiper_one),
        .stack_select(stack_select), .wipers_valid(wipers_valid), .tap_zero(tap_zero),
        .tap_one(tap_one), .stacked_code(stacked_code), .stacked_is_one(stacked_is_one));
    pot_host_end pot_host_end_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .link(link_bus.host), .start(start), .readback(readback), .devices(devices),
        .tx_frame(tx_frame), .busy(busy), .done(done), .rx_frame(rx_frame));
    pot_link_properties pot_link_properties_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .port_enable(link_bus.port_enable), .serial_clk(link_bus.serial_clk),
        .host_data(link_bus.host_data), .host_data_oe(link_bus.host_data_oe),
        .cascade_out(link_bus.cascade_out), .serial_data(link_bus.serial_data));
    task automatic check(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [7:0] code_at(input logic [16:0] r, input int msb);
        logic [7:0] c;
        for (int i = 0; i < CODE_BITS; i++)
            c[CODE_BITS - 1 - i] = r[msb + i];
        return c;
    endfunction
    // A single device keeps only the last unit of a longer chain frame.
    task automatic run(input logic rb, input int d, input logic [67:0] f);
        logic [7:0] c0;
        logic [7:0] c1;
        int i;
        @(posedge ref_clk);
        start <= 1'b1;
        readback <= rb;
        devices <= 3'(d);
        tx_frame <= f;
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (1500) @(posedge ref_clk);
        @(negedge ref_clk);
        if (loaded)
            check(wiper_zero === code_at(reg_now, 9) && wiper_one === code_at(reg_now, 1),
                "wipers moved mid frame");
        @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        for (i = 0; i < 20000 && done !== 1'b1; i++)
            @(negedge ref_clk);
        if (i == 20000)
        begin
            check(1'b0, "no done");
            end_of_test();
        end
        // Received bits enter at the top, so the last unit read sits in the top 17 bits.
        if (loaded && (rb || d == 1))
            check(rx_frame[67 -: 17] === reg_now, "cascade data wrong");
        if (!rb)
            reg_now = 17'(f >> (FRAME_BITS * (d - 1)));
        loaded = 1'b1;
        c0 = code_at(reg_now, CODE_ZERO_MSB_POS);
        c1 = code_at(reg_now, CODE_ONE_MSB_POS);
        repeat (3) @(negedge ref_clk);
        check(wiper_zero === c0 && wiper_one === c1, "wiper codes");
        check(stack_select === reg_now[STACK_POS], "stack bit");
        check(tap_zero === (256'h1 << c0) && tap_one === (256'h1 << c1), "taps");
        check(stacked_code === (reg_now[0] ? c1 : c0), "stacked code");
        check(stacked_is_one === reg_now[0], "stacked select");
        check(wipers_valid === 1'b1 && busy === 1'b0, "valid or busy");
        $display("test done readback %0d devices %0d", rb, d);
    endtask
    initial
    begin
        logic [67:0] f;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        check(wipers_valid === 1'b0, "valid after reset");
        run(1'b0, 1, {68{1'b1}});
        run(1'b1, 1, 68'h0);
        for (int k = 0; k < 10; k++)
        begin
            f = 68'({$random(seed), $random(seed), $random(seed)});
            run(k % 3 == 2, k < 4 ? 1 : 1 + ($unsigned($random(seed)) % 4), f);
        end
        run(1'b0, 4, 68'h0);
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== tb/pot_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pot_link_properties
    import pot_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic port_enable,
    input wire logic serial_clk,
    input wire logic host_data,
    input wire logic host_data_oe,
    input wire logic cascade_out,
    input wire logic serial_data
);
    logic clk_q;
    logic [7:0] rises;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Rising link clocks are counted per frame so a short frame shows at enable fall.
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clk_q <= 1'b0;
            rises <= 8'h00;
        end
        else
        begin
            clk_q <= serial_clk;
            rises <= port_enable ? rises + 8'(serial_clk & ~clk_q) : 8'h00;
        end
    end
    chk_clk_idle_low: assert property (
        !port_enable |-> !serial_clk) else $error("link clock high outside a frame");
    chk_enable_setup: assert property (
        $rose(port_enable) |-> !serial_clk [*8]) else $error("clock too soon after enable");
    chk_enable_gap: assert property (
        $fell(port_enable) |-> !port_enable [*8]) else $error("enable gap too short");
    chk_clk_high_hold: assert property (
        $rose(serial_clk) |-> serial_clk [*8]) else $error("link clock high too short");
    chk_clk_low_hold: assert property (
        $fell(serial_clk) |-> !serial_clk [*8]) else $error("link clock low too short");
    chk_data_setup: assert property (
        $rose(serial_clk) && host_data_oe |-> $stable(host_data)) else $error("data moved at edge");
    chk_loop_setup: assert property (
        $rose(serial_clk) |-> $stable(serial_data)) else $error("looped data moved at edge");
    chk_frame_count: assert property (
        $fell(port_enable) |-> rises != 8'h00 && rises % FRAME_BITS == 0)
        else $error("frame not a whole number of units");
    chk_idle_hold: assert property (
        !port_enable [*8] |-> $stable(cascade_out)) else $error("cascade moved while idle");
    chk_shift_on_clk: assert property (
        port_enable && $past(port_enable, 8) && $changed(cascade_out) |-> serial_clk)
        else $error("cascade moved without a clock");
    cover property (port_enable && !host_data_oe && $rose(serial_clk));
    cover property ($fell(port_enable) && rises == 8'h44);
    cover property ($fell(port_enable) && rises == 8'h11);
endmodule
`default_nettype wire
